// ---- rtl/srr_pkg.sv ----
/*
 Constants, register map and types for the engine speed reference ramp.
 Assumes a 100 MHz system clock and a synchronous active-high reset.
*/
// Contract
// - Raise or lower contact moves reference at its rate within bounds.
// - Raise and lower contacts stay active while the engine is stopped.
// - With idle at stop, a contact after stop overrides idle reference.
// - Maneuver input ramps reference to maneuver setpoint at the up rate.
// - Remote mode ramps toward remote or serial value, even when stopped.
// - Remote target is a straight line between the two end setpoints.
// - Reference steps toward remote target at its rate, never past bounds.
// - Remote input below 2 mA or above 22 mA counts as failed.
// - On remote fault hold last reference, or ramp to lower bound.
// - Raise and lower contacts still adjust while remote input failed.
// - Fault latches after delay; clears on alarm reset once input valid.
// - Clutch ramps follower to master at catch-up rate, then tracks.
// - Load share bias added after limiter only when clutched and enabled.
// - Percent load from rack calibration, else from drive output calib.
// - Auxiliary bias added only when aux enable and external sync set.
// - Monitor reads ramped reference plus load share and aux biases.
// - Both contacts select remote; serial select picks the bus value.
// - Power-up or stopped with idle at stop snaps to idle setpoint.
// - A follower on clutch request ignores own up and down rates and follows the master reference.
package srr_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int REF_W = 16;
    localparam int CLK_HZ = 100000000;
    // Fast loop tick keeps each step small for the speed loop
    localparam int TICK_HZ = 10000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    // Input current in microamps
    localparam logic [15:0] MA4_UA = 16'h0fa0;
    localparam logic [15:0] MA20_UA = 16'h4e20;
    localparam logic [15:0] MA2_UA = 16'h07d0;
    localparam logic [15:0] MA22_UA = 16'h55f0;
    localparam logic [15:0] MA_SPAN_UA = 16'h3e80;
    // Fault delay in clocks
    localparam logic [15:0] FAULT_DLY_RST = 16'h03e8;
    localparam logic [15:0] FAST_RATE = 16'hffff;
    // Word offsets (byte address = 4 * index)
    localparam logic [ADDR_W-1:0] R_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] R_LOWER = 6'h01;
    localparam logic [ADDR_W-1:0] R_UPPER = 6'h02;
    localparam logic [ADDR_W-1:0] R_IDLE = 6'h03;
    localparam logic [ADDR_W-1:0] R_UPRATE = 6'h04;
    localparam logic [ADDR_W-1:0] R_DNRATE = 6'h05;
    localparam logic [ADDR_W-1:0] R_MANEUVER = 6'h06;
    localparam logic [ADDR_W-1:0] R_REM_LO = 6'h07;
    localparam logic [ADDR_W-1:0] R_REM_HI = 6'h08;
    localparam logic [ADDR_W-1:0] R_SERIAL = 6'h09;
    localparam logic [ADDR_W-1:0] R_CATCHUP = 6'h0a;
    localparam logic [ADDR_W-1:0] R_FDELAY = 6'h0b;
    localparam logic [ADDR_W-1:0] R_RACK_CAL = 6'h0c;
    localparam logic [ADDR_W-1:0] R_DRIVE_CAL = 6'h0d;
    localparam logic [ADDR_W-1:0] R_STATUS = 6'h0e;
    localparam logic [ADDR_W-1:0] R_REF = 6'h0f;
    localparam logic [ADDR_W-1:0] R_MONITOR = 6'h10;
    localparam logic [ADDR_W-1:0] R_LOAD = 6'h11;
    // Control register bits
    localparam int C_IDLE_STOP = 0;
    localparam int C_HOLD_FLT = 1;
    localparam int C_SERIAL_SEL = 2;
    localparam int C_LS_EN = 3;
    localparam int C_AUX_EN = 4;
    localparam int C_EXT_SYNC = 5;
    localparam int CTRL_W = 6;
    // Reset values
    localparam logic [REF_W-1:0] LOWER_RST = 16'h0190;
    localparam logic [REF_W-1:0] UPPER_RST = 16'h0384;
    localparam logic [REF_W-1:0] IDLE_RST = 16'h012c;
    localparam logic [REF_W-1:0] RATE_RST = 16'h000a;
    localparam logic [REF_W-1:0] CATCH_RST = 16'h0005;
    localparam logic [REF_W-1:0] MAN_RST = 16'h0258;
    typedef enum logic [2:0] {
        SRR_IDLE, SRR_LOCAL, SRR_MANEUVER, SRR_REMOTE, SRR_FAULTED,
        SRR_CATCHUP, SRR_TRACK
    } srr_mode_type;
endpackage : srr_pkg

// ---- rtl/srr_stepper.sv ----
/*
 One ramp step toward a target with separate up and down step sizes.
 Assumes the caller clamps the target to the reference bounds in all modes except idle, catch-up and track.
*/
`timescale 1ns/1ps
module srr_stepper (
    input wire logic [srr_pkg::REF_W-1:0] cur,
    input wire logic [srr_pkg::REF_W-1:0] target,
    input wire logic [srr_pkg::REF_W-1:0] up_step,
    input wire logic [srr_pkg::REF_W-1:0] dn_step,
    output logic [srr_pkg::REF_W-1:0] next_val
);
    import srr_pkg::*;
    logic [REF_W:0] sum;
    always_comb begin
        sum = {1'b0, cur} + {1'b0, up_step};
        if (target > cur) begin
            // Stop exactly at the target so no step overshoots a bound
            next_val = (sum >= {1'b0, target}) ? target : sum[REF_W-1:0];
        end else if (target < cur) begin
            next_val = (cur - target <= dn_step) ? target : cur - dn_step;
        end else begin
            next_val = cur;
        end
    end
endmodule : srr_stepper

// ---- rtl/srr_ref_ramp.sv ----
/*
 Speed reference ramp with Avalon-MM register slave and loop tick divider.
 Assumes contact, current and bias inputs are synchronous to CLK_SYS.
*/
`timescale 1ns/1ps
module srr_ref_ramp (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [srr_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [srr_pkg::DATA_W-1:0] AVS_WRITEDATA,
    output logic [srr_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic RAISE,
    input wire logic LOWER,
    input wire logic MANEUVER,
    input wire logic RUNNING,
    input wire logic FOLLOWER,
    input wire logic CLUTCH_REQ,
    input wire logic BOTH_CLUTCHED,
    input wire logic ALARM_RESET,
    input wire logic [15:0] REMOTE_UA,
    input wire logic [srr_pkg::REF_W-1:0] MASTER_REF,
    input wire logic [15:0] RACK_POS,
    input wire logic RACK_FAIL,
    input wire logic [15:0] DRIVE_OUT,
    input wire logic signed [15:0] LS_BIAS,
    input wire logic signed [15:0] AUX_BIAS,
    output logic [srr_pkg::REF_W-1:0] REF_OUT,
    output logic [srr_pkg::REF_W-1:0] BIASED_REF,
    output logic [15:0] PERCENT_LOAD,
    output logic REMOTE_FAULT
);
    import srr_pkg::*;
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [REF_W-1:0] lower_b, upper_b, idle_sp, up_rate, dn_rate;
    logic [REF_W-1:0] maneuver_setpoint, remote_low_end_ref;
    logic [REF_W-1:0] remote_high_end_ref, serial_ref, follower_catchup_rate;
    logic [15:0] fault_delay;
    logic [31:0] rack_cal, drive_cal;
    logic [REF_W-1:0] next_lower_b, next_upper_b, next_idle_sp;
    logic [REF_W-1:0] next_up_rate, next_dn_rate, next_maneuver;
    logic [REF_W-1:0] next_rem_lo, next_rem_hi, next_serial, next_catch;
    logic [15:0] next_fault_delay;
    logic [31:0] next_rack_cal, next_drive_cal;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic rd_done, next_rd_done;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic tick;
    logic [REF_W-1:0] ref_q, next_ref;
    srr_mode_type mode, next_mode;
    logic [15:0] flt_cnt, next_flt_cnt;
    logic flt_latch, next_flt_latch, alarm_q, next_alarm_q;
    logic was_running, next_was_running, override, next_override;
    logic [REF_W-1:0] target, up_step, dn_step, step_out, remote_tgt;
    logic remote_bad, remote_sel;
    logic [31:0] interp;
    logic signed [17:0] biased;
    logic [15:0] pct;
    logic [15:0] cal_lo, cal_hi, load_src;

    // Register bus: one wait state on reads, writes take effect at once
    assign AVS_WAITREQUEST = AVS_READ && !rd_done;
    assign AVS_READDATA = rdata;

    always_comb begin
        next_ctrl = ctrl;
        next_lower_b = lower_b;
        next_upper_b = upper_b;
        next_idle_sp = idle_sp;
        next_up_rate = up_rate;
        next_dn_rate = dn_rate;
        next_maneuver = maneuver_setpoint;
        next_rem_lo = remote_low_end_ref;
        next_rem_hi = remote_high_end_ref;
        next_serial = serial_ref;
        next_catch = follower_catchup_rate;
        next_fault_delay = fault_delay;
        next_rack_cal = rack_cal;
        next_drive_cal = drive_cal;
        next_rd_done = AVS_READ && !rd_done;
        next_rdata = rdata;
        if (AVS_WRITE) begin
            unique case (AVS_ADDRESS)
                R_CTRL: next_ctrl = AVS_WRITEDATA[CTRL_W-1:0];
                R_LOWER: next_lower_b = AVS_WRITEDATA[REF_W-1:0];
                R_UPPER: next_upper_b = AVS_WRITEDATA[REF_W-1:0];
                R_IDLE: next_idle_sp = AVS_WRITEDATA[REF_W-1:0];
                R_UPRATE: next_up_rate = AVS_WRITEDATA[REF_W-1:0];
                R_DNRATE: next_dn_rate = AVS_WRITEDATA[REF_W-1:0];
                R_MANEUVER: next_maneuver = AVS_WRITEDATA[REF_W-1:0];
                R_REM_LO: next_rem_lo = AVS_WRITEDATA[REF_W-1:0];
                R_REM_HI: next_rem_hi = AVS_WRITEDATA[REF_W-1:0];
                R_SERIAL: next_serial = AVS_WRITEDATA[REF_W-1:0];
                R_CATCHUP: next_catch = AVS_WRITEDATA[REF_W-1:0];
                R_FDELAY: next_fault_delay = AVS_WRITEDATA[15:0];
                R_RACK_CAL: next_rack_cal = AVS_WRITEDATA;
                R_DRIVE_CAL: next_drive_cal = AVS_WRITEDATA;
                default: ;
            endcase
        end
        if (AVS_READ && !rd_done) begin
            unique case (AVS_ADDRESS)
                R_CTRL: next_rdata = {26'h0, ctrl};
                R_LOWER: next_rdata = {16'h0, lower_b};
                R_UPPER: next_rdata = {16'h0, upper_b};
                R_IDLE: next_rdata = {16'h0, idle_sp};
                R_UPRATE: next_rdata = {16'h0, up_rate};
                R_DNRATE: next_rdata = {16'h0, dn_rate};
                R_MANEUVER: next_rdata = {16'h0, maneuver_setpoint};
                R_REM_LO: next_rdata = {16'h0, remote_low_end_ref};
                R_REM_HI: next_rdata = {16'h0, remote_high_end_ref};
                R_SERIAL: next_rdata = {16'h0, serial_ref};
                R_CATCHUP: next_rdata = {16'h0, follower_catchup_rate};
                R_FDELAY: next_rdata = {16'h0, fault_delay};
                R_RACK_CAL: next_rdata = rack_cal;
                R_DRIVE_CAL: next_rdata = drive_cal;
                R_STATUS: next_rdata = {27'h0, mode, remote_bad, flt_latch};
                R_REF: next_rdata = {16'h0, ref_q};
                R_MONITOR: next_rdata = {16'h0, BIASED_REF};
                R_LOAD: next_rdata = {16'h0, PERCENT_LOAD};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ctrl <= '0;
            lower_b <= LOWER_RST;
            upper_b <= UPPER_RST;
            idle_sp <= IDLE_RST;
            up_rate <= RATE_RST;
            dn_rate <= RATE_RST;
            maneuver_setpoint <= MAN_RST;
            remote_low_end_ref <= LOWER_RST;
            remote_high_end_ref <= UPPER_RST;
            serial_ref <= LOWER_RST;
            follower_catchup_rate <= CATCH_RST;
            fault_delay <= FAULT_DLY_RST;
            rack_cal <= 32'h0;
            drive_cal <= 32'h0;
            rd_done <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ctrl <= next_ctrl;
            lower_b <= next_lower_b;
            upper_b <= next_upper_b;
            idle_sp <= next_idle_sp;
            up_rate <= next_up_rate;
            dn_rate <= next_dn_rate;
            maneuver_setpoint <= next_maneuver;
            remote_low_end_ref <= next_rem_lo;
            remote_high_end_ref <= next_rem_hi;
            serial_ref <= next_serial;
            follower_catchup_rate <= next_catch;
            fault_delay <= next_fault_delay;
            rack_cal <= next_rack_cal;
            drive_cal <= next_drive_cal;
            rd_done <= next_rd_done;
            rdata <= next_rdata;
        end
    end

    // Loop tick divider; rates are speed units per tick
    always_comb begin
        tick = (tick_cnt == 32'(TICK_DIV - 1));
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    end

    // Remote mapping; the end setpoints must lie inside the bounds
    always_comb begin
        remote_bad = (REMOTE_UA < MA2_UA) || (REMOTE_UA > MA22_UA);
        if (REMOTE_UA <= MA4_UA) begin
            interp = 32'h0;
        end else if (REMOTE_UA >= MA20_UA) begin
            interp = 32'(MA_SPAN_UA);
        end else begin
            interp = 32'(REMOTE_UA - MA4_UA);
        end
        if (remote_high_end_ref >= remote_low_end_ref) begin
            remote_tgt = remote_low_end_ref + REF_W'(
                (32'(remote_high_end_ref - remote_low_end_ref) * interp)
                / 32'(MA_SPAN_UA));
        end else begin
            remote_tgt = remote_low_end_ref - REF_W'(
                (32'(remote_low_end_ref - remote_high_end_ref) * interp)
                / 32'(MA_SPAN_UA));
        end
        if (ctrl[C_SERIAL_SEL]) begin
            remote_tgt = serial_ref;
        end
    end

    // Mode selection and ramp target
    always_comb begin
        remote_sel = RAISE && LOWER && !FOLLOWER;
        next_was_running = RUNNING;
        next_override = override;
        if (was_running && !RUNNING) begin
            next_override = 1'b0;
        end
        if (!RUNNING && (RAISE || LOWER)) begin
            next_override = 1'b1;
        end
        if (FOLLOWER && (CLUTCH_REQ || mode == SRR_TRACK)) begin
            next_mode = (mode == SRR_TRACK || ref_q == MASTER_REF) ?
                SRR_TRACK : SRR_CATCHUP;
        end else if (!RUNNING && ctrl[C_IDLE_STOP] && !override) begin
            next_mode = SRR_IDLE;
        end else if (remote_sel && ctrl[C_SERIAL_SEL]) begin
            next_mode = SRR_REMOTE;
        end else if (remote_sel && (remote_bad || flt_latch)) begin
            next_mode = SRR_FAULTED;
        end else if (remote_sel) begin
            next_mode = SRR_REMOTE;
        end else if (MANEUVER) begin
            next_mode = SRR_MANEUVER;
        end else begin
            next_mode = SRR_LOCAL;
        end
        up_step = up_rate;
        dn_step = dn_rate;
        target = ref_q;
        unique case (mode)
            SRR_IDLE: begin
                target = idle_sp;
                up_step = FAST_RATE;
                dn_step = FAST_RATE;
            end
            SRR_LOCAL: begin
                // contacts act whether or not running
                if (RAISE) target = upper_b;
                else if (LOWER) target = lower_b;
            end
            SRR_MANEUVER: begin
                target = maneuver_setpoint;
                dn_step = up_rate;
            end
            SRR_REMOTE: target = remote_tgt;
            SRR_FAULTED: begin
                target = ctrl[C_HOLD_FLT] ? ref_q : lower_b;
                // a single contact still trims while faulted
            end
            SRR_CATCHUP: begin
                target = MASTER_REF;
                up_step = follower_catchup_rate;
                dn_step = follower_catchup_rate;
            end
            SRR_TRACK: begin
                target = MASTER_REF;
                up_step = FAST_RATE;
                dn_step = FAST_RATE;
            end
        endcase
        if (mode != SRR_IDLE && mode != SRR_CATCHUP && mode != SRR_TRACK) begin
            if (target > upper_b) target = upper_b;
            if (target < lower_b) target = lower_b;
        end
        next_ref = tick ? step_out : ref_q;
        next_alarm_q = ALARM_RESET;
        next_flt_cnt = remote_bad ? ((flt_cnt == 16'hffff) ?
            flt_cnt : flt_cnt + 16'h1) : 16'h0;
        next_flt_latch = flt_latch;
        if (!remote_bad && ALARM_RESET != alarm_q) begin
            next_flt_latch = 1'b0;
        end
        if (remote_bad && flt_cnt >= fault_delay) begin
            next_flt_latch = 1'b1;
        end
    end

    srr_stepper u_step (
        .cur(ref_q),
        .target(target),
        .up_step(up_step),
        .dn_step(dn_step),
        .next_val(step_out)
    );

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            tick_cnt <= 32'h0;
            ref_q <= IDLE_RST;
            mode <= SRR_IDLE;
            flt_cnt <= 16'h0;
            flt_latch <= 1'b0;
            alarm_q <= 1'b0;
            was_running <= 1'b0;
            override <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            ref_q <= next_ref;
            mode <= next_mode;
            flt_cnt <= next_flt_cnt;
            flt_latch <= next_flt_latch;
            alarm_q <= next_alarm_q;
            was_running <= next_was_running;
            override <= next_override;
        end
    end

    // Biases sit after the limiter so load sharing is never rate limited
    always_comb begin
        biased = 18'(signed'({2'b00, ref_q}));
        if (BOTH_CLUTCHED && ctrl[C_LS_EN]) begin
            biased = biased + 18'(LS_BIAS);
        end
        if (ctrl[C_AUX_EN] && ctrl[C_EXT_SYNC]) begin
            biased = biased + 18'(AUX_BIAS);
        end
        // low half is no-load point, high half full-load point
        cal_lo = RACK_FAIL ? drive_cal[15:0] : rack_cal[15:0];
        cal_hi = RACK_FAIL ? drive_cal[31:16] : rack_cal[31:16];
        load_src = RACK_FAIL ? DRIVE_OUT : RACK_POS;
        if (cal_hi <= cal_lo || load_src <= cal_lo) begin
            pct = 16'h0;
        end else begin
            pct = 16'((32'(load_src - cal_lo) * 32'd100) /
                32'(cal_hi - cal_lo));
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            BIASED_REF <= '0;
            PERCENT_LOAD <= 16'h0;
        end else begin
            BIASED_REF <= biased[17] ? '0 : biased[REF_W-1:0];
            PERCENT_LOAD <= pct;
        end
    end

    assign REF_OUT = ref_q;
    assign REMOTE_FAULT = flt_latch;

    fault_latch_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        remote_bad && flt_cnt >= fault_delay |=> flt_latch)
        else $error("remote fault not latched");
    tick_hold_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !tick |=> $stable(ref_q))
        else $error("reference moved between ticks");
    bound_keep_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        tick && mode == SRR_LOCAL && ref_q <= upper_b && ref_q >= lower_b
        |=> ref_q <= upper_b && ref_q >= lower_b)
        else $error("reference left bounds");
    idle_snap_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        tick && mode == SRR_IDLE |=> ref_q == idle_sp)
        else $error("idle not reached in one tick");
    fail_det_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        REMOTE_UA < MA2_UA |=> flt_cnt != 16'h0)
        else $error("under range not detected");
    track_fast_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        tick && mode == SRR_TRACK && $stable(MASTER_REF)
        |=> ref_q == MASTER_REF)
        else $error("follower not tracking");
endmodule : srr_ref_ramp

// ---- tb/srr_partner.sv ----
/*
 Operator contacts, remote setpoint source and alarm reset switch.
 Assumes the bench asks for changes just after a rising clock edge.
*/
`timescale 1ns/1ps
module srr_partner (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] want_contacts,
    input wire logic [15:0] want_ua,
    input wire logic want_toggle,
    output logic raise,
    output logic lower,
    output logic [15:0] remote_ua,
    output logic alarm_reset
);
    // Outputs move on the clock only, so the ramp never sees half a change
    always_ff @(posedge clk) begin
        raise <= want_contacts[1];
        lower <= want_contacts[0];
        remote_ua <= want_ua;
        if (srst) begin
            alarm_reset <= 1'b0;
        end else if (want_toggle) begin
            alarm_reset <= ~alarm_reset;
        end
    end
endmodule : srr_partner

// ---- tb/test_srr_ref_ramp.sv ----
/*
 Self-checking bench for the speed reference ramp.
 Assumes a loop tick every 10000 clocks, so each ramp step costs a tick.
*/
`timescale 1ns/1ps
module test_srr_ref_ramp;
    import srr_pkg::*;
    typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} srr_row_type;
    logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, raise, lower, alarm_reset, remote_fault;
    logic [1:0] want_c = 2'h0;
    logic [15:0] want_ua = 16'h2ee0, remote_ua, percent_load;
    logic want_t = 1'b0, running = 1'b0;
    logic maneuver = 1'b0, follower = 1'b0, clutch = 1'b0, clutched = 1'b0;
    logic [15:0] master_ref = 16'h0136;
    logic [15:0] ref_out, biased_ref;
    int err_total = 0, checks = 0, cyc = 0;
    srr_row_type rows [10] = '{
        '{R_LOWER, 32'h0100, 32'h0100}, '{R_UPPER, 32'h0136, 32'h0136},
        '{R_UPRATE, 32'h0014, 32'h0014}, '{R_DNRATE, 32'h0005, 32'h0005},
        '{R_REM_LO, 32'h0100, 32'h0100},
        '{R_REM_HI, 32'h0136, 32'h0136},
        '{R_FDELAY, 32'h0010, 32'h0010},
        '{R_RACK_CAL, 32'h03e80000, 32'h03e80000},
        '{R_CTRL, 32'h0030, 32'h0030}, '{6'h3f, 32'h1234, 32'h0}};
    always #5 clk = ~clk;
    srr_partner i_partner (.clk(clk), .srst(srst), .want_contacts(want_c),
        .want_ua(want_ua), .want_toggle(want_t), .raise(raise),
        .lower(lower), .remote_ua(remote_ua), .alarm_reset(alarm_reset));
    // Rack and bias inputs stay fixed; their gating is checked instead
    srr_ref_ramp i_dut (.CLK_SYS(clk), .SRST(srst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .RAISE(raise), .LOWER(lower),
        .MANEUVER(maneuver), .RUNNING(running), .FOLLOWER(follower),
        .CLUTCH_REQ(clutch), .BOTH_CLUTCHED(clutched),
        .ALARM_RESET(alarm_reset), .REMOTE_UA(remote_ua),
        .MASTER_REF(master_ref), .RACK_POS(16'h01f4),
        .RACK_FAIL(1'b0), .DRIVE_OUT(16'h0000), .LS_BIAS(16'sh0007),
        .AUX_BIAS(16'sh0005), .REF_OUT(ref_out), .BIASED_REF(biased_ref),
        .PERCENT_LOAD(percent_load), .REMOTE_FAULT(remote_fault));
    task automatic end_of_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        // Hold the request until waitrequest is seen low at a rising edge
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) err_total++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wait_tick;
        logic [15:0] old;
        int n;
        old = ref_out;
        n = 0;
        while (ref_out === old && n < 11000) begin
            @(posedge clk);
            n++;
        end
        if (n == 11000) err_total++;
        repeat (3) @(posedge clk);
    endtask : wait_tick
    always @(posedge clk) begin
        cyc++;
        // Six ticks plus set-up; a hang ends the run here
        if (cyc == 80000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("ref_rst", {16'h0, IDLE_RST}, {16'h0, ref_out});
        chk("flt_rst", 32'h0, {31'h0, remote_fault});
        chk("wait_rst", 32'h0, {31'h0, avs_waitrequest});
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, q);
            bus(1'b0, rows[i].a, 32'h0, q);
            chk("reg", rows[i].e, q);
        end
        running <= 1'b1;
        want_c <= 2'h2;
        wait_tick();
        chk("ref_raise", 32'h0136, {16'h0, ref_out});
        chk("biased", 32'h013b, {16'h0, biased_ref});
        chk("load", 32'h0032, {16'h0, percent_load});
        want_c <= 2'h3;
        want_ua <= 16'h0000;
        repeat (40) @(posedge clk);
        chk("flt_set", 32'h1, {31'h0, remote_fault});
        wait_tick();
        chk("ref_flt", 32'h0131, {16'h0, ref_out});
        want_ua <= MA20_UA;
        repeat (5) @(posedge clk);
        want_t <= 1'b1;
        @(posedge clk);
        want_t <= 1'b0;
        repeat (5) @(posedge clk);
        chk("flt_clr", 32'h0, {31'h0, remote_fault});
        wait_tick();
        chk("ref_rem", 32'h0136, {16'h0, ref_out});
        bus(1'b0, R_REF, 32'h0, q);
        chk("rd_ref", 32'h0136, q);
        bus(1'b0, R_MONITOR, 32'h0, q);
        chk("rd_mon", 32'h013b, q);
        want_c <= 2'h0;
        maneuver <= 1'b1;
        bus(1'b1, R_MANEUVER, 32'h0120, q);
        wait_tick();
        chk("ref_man", 32'h0122, {16'h0, ref_out});
        maneuver <= 1'b0;
        bus(1'b1, R_CTRL, 32'h0038, q);
        follower <= 1'b1;
        clutch <= 1'b1;
        clutched <= 1'b1;
        master_ref <= 16'h012c;
        wait_tick();
        chk("ref_catch", 32'h0127, {16'h0, ref_out});
        master_ref <= 16'h0127;
        repeat (3) @(posedge clk);
        master_ref <= 16'h0200;
        wait_tick();
        chk("ref_track", 32'h0200, {16'h0, ref_out});
        chk("biased_ls", 32'h020c, {16'h0, biased_ref});
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("ref_rst2", {16'h0, IDLE_RST}, {16'h0, ref_out});
        chk("mon_rst2", 32'h0, {16'h0, biased_ref});
        bus(1'b0, R_CTRL, 32'h0, q);
        chk("ctrl_rst2", 32'h0, q);
        end_of_test();
    end
endmodule : test_srr_ref_ramp
